// ---- mewc_top.sv ----
// Motion engine control, feature enables, engine rate timer and wake-on-motion detector.
// Assumes same-clock register strobes and accelerometer samples from on-chip logic.
//
// What this block does
// - Initialise bit starts sequence, clears itself after
// - Initialise pending masks all other features
// - Memory clear bit wipes engine working SRAM
// - Power-save bit selects low-power engine operation
// - Feature bit 6 enables significant motion
// - Feature bit 5 enables freefall detection
// - Feature bit 4 enables tilt detection
// - Feature bit 3 enables step counter
// - Writes accepted anytime, applied while running
// - Rate field selects 25/400/50/100 Hz engine
// - Wake fires on first..fourth over-threshold event
// - Combine bit chooses OR or AND axes
// - Reference mode: fixed first or previous sample
// - Bit 0 enables wake; host freezes fields
module mewc_top
	import mewc_pkg::*;
#(
	parameter int unsigned DIV_25  = MEWC_DIV_25,
	parameter int unsigned DIV_400 = MEWC_DIV_400,
	parameter int unsigned DIV_50  = MEWC_DIV_50,
	parameter int unsigned DIV_100 = MEWC_DIV_100
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic [7:0]        reg_rdata,
	output logic              irq,
	input  wire logic         sample_valid,
	input  wire mewc_sample_t sample,
	input  wire logic [2:0]   axis_enable,
	input  wire logic [15:0]  wake_threshold,
	output mewc_feat_t        feature_out,
	output logic              engine_power_save,
	output logic              engine_busy,
	output logic              engine_tick,
	output logic              mem_clear_we,
	output logic [7:0]        mem_clear_addr,
	output logic              wake_event
);

	// Absolute difference of two samples, widened so it never wraps
	function automatic logic [16:0] abs_diff(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		return d[16] ? 17'(-d) : 17'(d);
	endfunction : abs_diff

	// Cycles per engine tick for a rate code
	function automatic logic [19:0] rate_period(input mewc_rate_t r);
		unique case (r)
			MEWC_RATE_25:  return 20'(DIV_25);
			MEWC_RATE_400: return 20'(DIV_400);
			MEWC_RATE_50:  return 20'(DIV_50);
			MEWC_RATE_100: return 20'(DIV_100);
		endcase
	endfunction : rate_period

	mewc_ctrl_t   ctrl_reg,   ctrl_next;
	mewc_feat_t   feat_reg,   feat_next;
	mewc_wake_t   wake_reg,   wake_next;
	logic [7:0]   mask_reg,   mask_next;
	logic [7:0]   stat_reg,   stat_next;
	logic [7:0]   rdata_reg,  rdata_next;
	mewc_feat_t   fout_reg,   fout_next;
	logic         psave_reg,  psave_next;
	mewc_state_t  state_reg,  state_next;
	logic [7:0]   cnt_reg,    cnt_next;
	logic [19:0]  div_reg,    div_next;
	logic         tick_reg,   tick_next;
	mewc_sample_t ref_reg,    ref_next;
	logic         refv_reg,   refv_next;
	logic [1:0]   evt_reg,    evt_next;
	logic         wev_reg,    wev_next;
	logic         init_done;
	logic         clr_done;
	logic         wr_ctrl;
	logic         wr_stat;
	logic [7:0]   hw_set;

	// Sequence completion strobes seen by the register group
	assign init_done = (state_reg == MEWC_ST_INIT) && (cnt_reg == MEWC_INIT_LAST);
	assign clr_done  = (state_reg == MEWC_ST_CLEAR) && (cnt_reg == MEWC_MEM_LAST);
	assign wr_ctrl   = reg_wr && (reg_addr == MEWC_ADDR_CTRL);
	assign wr_stat   = reg_wr && (reg_addr == MEWC_ADDR_IRQ_STAT);
	assign hw_set    = {5'h00, wev_reg, clr_done, init_done};

	// Register writes, self-clearing bits, sticky status and read port
	always_comb begin
		ctrl_next  = ctrl_reg;
		feat_next  = feat_reg;
		wake_next  = wake_reg;
		mask_next  = mask_reg;
		rdata_next = 8'h00;
		// Accepted in any state, sensor running or not
		if (wr_ctrl) begin
			ctrl_next = mewc_ctrl_t'(reg_wdata & 8'h0D);
		end else begin
			// Hardware drops the bit once its sequence ends
			if (init_done) begin
				ctrl_next.engine_initialise = 1'b0;
			end
			if (clr_done) begin
				ctrl_next.engine_memory_clear = 1'b0;
			end
		end
		if (reg_wr && reg_addr == MEWC_ADDR_FEAT) begin
			feat_next = mewc_feat_t'(reg_wdata & 8'h7B);
		end
		// Field freeze while enabled is the host's duty; the bits are stored as written
		if (reg_wr && reg_addr == MEWC_ADDR_WAKE) begin
			wake_next = mewc_wake_t'(reg_wdata & 8'h1F);
		end
		if (reg_wr && reg_addr == MEWC_ADDR_IRQ_MASK) begin
			mask_next = reg_wdata & MEWC_IRQ_USED;
		end
		// Set beats a write-one-to-clear in the same cycle
		stat_next = (stat_reg & ~(wr_stat ? reg_wdata : 8'h00)) | hw_set;
		if (reg_rd) begin
			unique case (reg_addr)
				MEWC_ADDR_CTRL:     rdata_next = ctrl_reg;
				MEWC_ADDR_FEAT:     rdata_next = feat_reg;
				MEWC_ADDR_WAKE:     rdata_next = wake_reg;
				MEWC_ADDR_IRQ_STAT: rdata_next = stat_reg;
				MEWC_ADDR_IRQ_MASK: rdata_next = mask_reg;
				MEWC_ADDR_ENG_STAT: rdata_next = {state_reg, refv_reg, evt_reg, 2'h0};
				default:            rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_reg  <= mewc_ctrl_t'(MEWC_CTRL_RST);
			feat_reg  <= mewc_feat_t'(MEWC_FEAT_RST);
			wake_reg  <= mewc_wake_t'(MEWC_WAKE_RST);
			mask_reg  <= MEWC_MASK_RST;
			stat_reg  <= MEWC_STAT_RST;
			rdata_reg <= 8'h00;
		end else begin
			ctrl_reg  <= ctrl_next;
			feat_reg  <= feat_next;
			wake_reg  <= wake_next;
			mask_reg  <= mask_next;
			stat_reg  <= stat_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq       = |(stat_reg & mask_reg);

	// Effective feature enables, all held off while initialising
	always_comb begin
		fout_next = feat_reg;
		fout_next.rsv_hi = 1'b0;
		fout_next.rsv_lo = 1'b0;
		if (ctrl_reg.engine_initialise) begin
			fout_next.significant_motion_on = 1'b0;
			fout_next.freefall_on           = 1'b0;
			fout_next.tilt_on               = 1'b0;
			fout_next.step_counter_on       = 1'b0;
		end
		// Bit positions 6..3 carry straight through the struct
		psave_next = ctrl_reg.engine_power_save;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fout_reg  <= mewc_feat_t'(8'h00);
			psave_reg <= 1'b0;
		end else begin
			fout_reg  <= fout_next;
			psave_reg <= psave_next;
		end
	end

	assign feature_out       = fout_reg;
	assign engine_power_save = psave_reg;

	// Engine sequencer: memory clear walks every word, initialise runs a fixed count
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			MEWC_ST_IDLE: begin
				cnt_next = 8'h00;
				// Clear goes first so initialise starts from a wiped memory
				if (ctrl_reg.engine_memory_clear) begin
					state_next = MEWC_ST_CLEAR;
				end else if (ctrl_reg.engine_initialise) begin
					state_next = MEWC_ST_INIT;
				end
			end
			MEWC_ST_CLEAR: begin
				cnt_next = cnt_reg + 8'h01;
				if (clr_done) begin
					state_next = MEWC_ST_IDLE;
				end
			end
			MEWC_ST_INIT: begin
				cnt_next = cnt_reg + 8'h01;
				if (init_done) begin
					state_next = MEWC_ST_IDLE;
				end
			end
			default: begin
				state_next = MEWC_ST_IDLE;
				cnt_next   = 8'h00;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= MEWC_ST_IDLE;
			cnt_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign engine_busy    = (state_reg != MEWC_ST_IDLE);
	assign mem_clear_we   = (state_reg == MEWC_ST_CLEAR);
	assign mem_clear_addr = cnt_reg;

	// Engine rate divider; a shorter new period takes effect at once
	always_comb begin
		div_next  = div_reg + 20'h00001;
		tick_next = 1'b0;
		if (engine_busy) begin
			div_next = 20'h00000;
		end else if (div_reg >= rate_period(feat_reg.engine_rate_select) - 20'h00001) begin
			div_next  = 20'h00000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			div_reg  <= 20'h00000;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign engine_tick = tick_reg;

	// Wake-on-motion: per-axis compare, combine, count, fire
	always_comb begin
		logic [2:0] over;
		logic       hit;
		over      = 3'h0;
		hit       = 1'b0;
		ref_next  = ref_reg;
		refv_next = refv_reg;
		evt_next  = evt_reg;
		wev_next  = 1'b0;
		if (!wake_reg.wake_detect_enable) begin
			refv_next = 1'b0;
			evt_next  = 2'h0;
		end else if (sample_valid) begin
			over[0] = abs_diff(sample.x, ref_reg.x) > {1'b0, wake_threshold};
			over[1] = abs_diff(sample.y, ref_reg.y) > {1'b0, wake_threshold};
			over[2] = abs_diff(sample.z, ref_reg.z) > {1'b0, wake_threshold};
			over    = over & axis_enable;
			// AND needs every enabled axis over, and at least one enabled
			hit = wake_reg.wake_axis_combine ?
				((&(over | ~axis_enable)) && (|axis_enable)) : (|over);
			// First sample only loads the reference, nothing to compare yet
			if (!refv_reg || wake_reg.wake_reference_mode) begin
				ref_next = sample;
			end
			refv_next = 1'b1;
			if (refv_reg && hit) begin
				if (evt_reg == wake_reg.wake_event_count) begin
					wev_next = 1'b1;
					evt_next = 2'h0;
				end else begin
					evt_next = evt_reg + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ref_reg  <= mewc_sample_t'(48'h000000000000);
			refv_reg <= 1'b0;
			evt_reg  <= 2'h0;
			wev_reg  <= 1'b0;
		end else begin
			ref_reg  <= ref_next;
			refv_reg <= refv_next;
			evt_reg  <= evt_next;
			wev_reg  <= wev_next;
		end
	end

	assign wake_event = wev_reg;

	// Checks on the block's own behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	init_self_clear_a: assert property (
		init_done && !wr_ctrl |=> !ctrl_reg.engine_initialise && stat_reg[MEWC_IRQ_INIT_DONE])
		else $error("initialise bit not cleared at end of sequence");

	init_masks_feat_a: assert property (
		ctrl_reg.engine_initialise |=> fout_reg[6:3] == 4'h0)
		else $error("features not masked during initialise");

	mem_clear_walk_a: assert property (
		$rose(mem_clear_we) |-> mem_clear_addr == 8'h00 ##1 mem_clear_addr == 8'h01)
		else $error("memory clear walk does not start at zero");

	// The output register resets to 0 while the control bit resets to 1, so skip that edge
	psave_follow_a: assert property (
		!$past(rst) |-> engine_power_save == $past(ctrl_reg.engine_power_save))
		else $error("power save output lags control bit");

	feat_write_a: assert property (
		reg_wr && reg_addr == MEWC_ADDR_FEAT && !ctrl_reg.engine_initialise
		##1 !ctrl_reg.engine_initialise |=> fout_reg[6:3] == $past(reg_wdata[6:3], 2))
		else $error("feature write not applied");

	tick_spacing_a: assert property (
		engine_tick |=> !engine_tick [*2])
		else $error("engine ticks too close together");

	wake_count_a: assert property (
		wake_event |-> $past(evt_reg) == $past(wake_reg.wake_event_count) && evt_reg == 2'h0)
		else $error("wake fired at wrong event count");

	wake_disable_a: assert property (
		!wake_reg.wake_detect_enable |=> evt_reg == 2'h0 && !refv_reg && !wake_event)
		else $error("wake state survives disable");

	stat_set_wins_a: assert property (
		wev_reg && wr_stat && reg_wdata[MEWC_IRQ_WAKE] |=> stat_reg[MEWC_IRQ_WAKE])
		else $error("wake status lost to clear");

	rdata_timing_a: assert property (
		reg_rd && reg_addr == MEWC_ADDR_CTRL |=> reg_rdata == $past(ctrl_reg))
		else $error("control read data wrong");

endmodule : mewc_top

// ---- mewc_pkg.sv ----
// Constants, register layouts and types for the motion engine and wake control block.
// Assumes a single 10 MHz clock and byte-wide registers at their own addresses.
package mewc_pkg;

	// Register addresses
	localparam logic [7:0] MEWC_ADDR_CTRL     = 8'h25;
	localparam logic [7:0] MEWC_ADDR_FEAT     = 8'h26;
	localparam logic [7:0] MEWC_ADDR_WAKE     = 8'h27;
	localparam logic [7:0] MEWC_ADDR_IRQ_STAT = 8'h30;
	localparam logic [7:0] MEWC_ADDR_IRQ_MASK = 8'h31;
	localparam logic [7:0] MEWC_ADDR_ENG_STAT = 8'h32;

	// Values after reset
	localparam logic [7:0] MEWC_CTRL_RST = 8'h08;
	localparam logic [7:0] MEWC_FEAT_RST = 8'h02;
	localparam logic [7:0] MEWC_WAKE_RST = 8'h00;
	localparam logic [7:0] MEWC_MASK_RST = 8'h00;
	localparam logic [7:0] MEWC_STAT_RST = 8'h00;

	// Interrupt status bit positions
	localparam int MEWC_IRQ_INIT_DONE = 0;
	localparam int MEWC_IRQ_CLR_DONE  = 1;
	localparam int MEWC_IRQ_WAKE      = 2;
	localparam logic [7:0] MEWC_IRQ_USED = 8'h07;

	// Clock and engine rates
	localparam int unsigned MEWC_CLK_HZ      = 10_000_000;
	localparam int unsigned MEWC_RATE_25_HZ  = 25;
	localparam int unsigned MEWC_RATE_400_HZ = 400;
	localparam int unsigned MEWC_RATE_50_HZ  = 50;
	localparam int unsigned MEWC_RATE_100_HZ = 100;
	localparam int unsigned MEWC_DIV_25      = MEWC_CLK_HZ / MEWC_RATE_25_HZ;
	localparam int unsigned MEWC_DIV_400     = MEWC_CLK_HZ / MEWC_RATE_400_HZ;
	localparam int unsigned MEWC_DIV_50      = MEWC_CLK_HZ / MEWC_RATE_50_HZ;
	localparam int unsigned MEWC_DIV_100     = MEWC_CLK_HZ / MEWC_RATE_100_HZ;

	// Sequence lengths
	localparam logic [7:0] MEWC_INIT_LAST = 8'h3F;
	localparam logic [7:0] MEWC_MEM_LAST  = 8'hFF;

	typedef enum logic [1:0] {
		MEWC_RATE_25  = 2'h0,
		MEWC_RATE_400 = 2'h1,
		MEWC_RATE_50  = 2'h2,
		MEWC_RATE_100 = 2'h3
	} mewc_rate_t;

	typedef enum logic [2:0] {
		MEWC_ST_IDLE  = 3'h1,
		MEWC_ST_INIT  = 3'h2,
		MEWC_ST_CLEAR = 3'h4
	} mewc_state_t;

	typedef struct packed {
		logic [3:0] rsv_hi;
		logic       engine_power_save;
		logic       engine_initialise;
		logic       rsv_lo;
		logic       engine_memory_clear;
	} mewc_ctrl_t;

	typedef struct packed {
		logic       rsv_hi;
		logic       significant_motion_on;
		logic       freefall_on;
		logic       tilt_on;
		logic       step_counter_on;
		logic       rsv_lo;
		mewc_rate_t engine_rate_select;
	} mewc_feat_t;

	typedef struct packed {
		logic [2:0] rsv;
		logic [1:0] wake_event_count;
		logic       wake_axis_combine;
		logic       wake_reference_mode;
		logic       wake_detect_enable;
	} mewc_wake_t;

	typedef struct packed {
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mewc_sample_t;

endpackage : mewc_pkg

// ---- mewc_host.sv ----
// Host model that owns the byte register port of the engine and wake block.
// Assumes ref_clk is shared with the block and strobes change after rising edges.
module mewc_host (
	input  wire logic       ref_clk,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet bus from time zero so nothing is taken during reset
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// One-cycle write, released only after the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand one cycle only, so sample just after the edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

endmodule : mewc_host

// ---- mewc_top_test.sv ----
// Self-checking bench for the motion engine and wake control block.
// Assumes the host model for register traffic and small engine rate dividers.
module mewc_top_test
	import mewc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic         ref_clk;
	logic         rst;
	logic [7:0]   reg_addr;
	logic [7:0]   reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic [7:0]   reg_rdata;
	logic         irq;
	logic         sample_valid;
	mewc_sample_t sample;
	logic [2:0]   axis_enable;
	logic [15:0]  wake_threshold;
	mewc_feat_t   feature_out;
	logic         engine_power_save;
	logic         engine_busy;
	logic         engine_tick;
	logic         mem_clear_we;
	logic [7:0]   mem_clear_addr;
	logic         wake_event;
	int           errors;
	int           checks_done;
	int           n;
	int           rgap[4] = '{16, 4, 12, 8};
	logic [7:0]   ra[6] = '{8'h25, 8'h26, 8'h27, 8'h30, 8'h31, 8'h40};
	logic [7:0]   rv[6] = '{8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

	// Short dividers keep each rate measurement to a few cycles
	mewc_top #(.DIV_25(16), .DIV_400(4), .DIV_50(12), .DIV_100(8)) u_mewc_top (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.sample_valid(sample_valid), .sample(sample), .axis_enable(axis_enable),
		.wake_threshold(wake_threshold), .feature_out(feature_out),
		.engine_power_save(engine_power_save), .engine_busy(engine_busy),
		.engine_tick(engine_tick), .mem_clear_we(mem_clear_we),
		.mem_clear_addr(mem_clear_addr), .wake_event(wake_event)
	);

	mewc_host u_mewc_host (
		.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_mewc_host.rd(a, d);
		chk(d, e);
	endtask : rchk

	// Counts clear-walk cycles until the sequencer is idle again
	task automatic run_busy(output int cnt);
		int k;
		cnt = 0;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			if (mem_clear_we) begin
				chk(mem_clear_addr, cnt[7:0]);
				cnt++;
			end
			k++;
		end while ((engine_busy || k < 3) && k < 400);
		@(posedge ref_clk);
		#1;
	endtask : run_busy

	// Gap between two ticks; the first tick may be a partial period
	task automatic tick_gap(output int g);
		int k;
		k = 0;
		g = 0;
		do begin @(posedge ref_clk); #1; k++; end while (!engine_tick && k < 100);
		do begin @(posedge ref_clk); #1; g++; end while (!engine_tick && g < 100);
	endtask : tick_gap

	// One sample; a wake may show in either of the two following cycles
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic e);
		logic got;
		@(posedge ref_clk);
		sample_valid <= 1'b1;
		sample       <= mewc_sample_t'({x, y, 16'h0000});
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		#1;
		got = wake_event;
		@(posedge ref_clk);
		#1;
		got = got | wake_event;
		chk(got, e);
	endtask : smp

	task automatic final_report;
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// Watchdog well beyond the under 1,500 cycles the tests need
	initial begin
		#2_000_000;
		errors++;
		final_report();
	end

	// Main sequence
	initial begin
		rst            = 1'b1;
		sample_valid   = 1'b0;
		sample         = '0;
		axis_enable    = 3'b011;
		wake_threshold = 16'h0032;
		errors         = 0;
		checks_done    = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ra[i]) rchk(ra[i], rv[i]);
		chk(feature_out, 8'h02);
		chk(engine_power_save, 1'b1);
		// Init pending masks features; a feature write meanwhile still lands
		u_mewc_host.wr(8'h31, 8'h07);
		u_mewc_host.wr(8'h25, 8'h0C);
		u_mewc_host.wr(8'h26, 8'hFF);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(feature_out, 8'h03);
		chk(engine_busy, 1'b1);
		rchk(8'h32, 8'h40);
		run_busy(n);
		chk(n, 0);
		chk(feature_out, 8'h7B);
		rchk(8'h25, 8'h08);
		rchk(8'h30, 8'h01);
		chk(irq, 1'b1);
		u_mewc_host.wr(8'h30, 8'h01);
		rchk(8'h30, 8'h00);
		chk(irq, 1'b0);
		// Every rate code, one feature bit each, memory clear restarts the tick
		for (int i = 0; i < 4; i++) begin
			u_mewc_host.wr(8'h26, (8'h08 << i) | i[1:0]);
			u_mewc_host.wr(8'h25, {4'h0, i[0], 3'b001});
			run_busy(n);
			chk(n, 256);
			rchk(8'h25, {4'h0, i[0], 3'b000});
			chk(feature_out, (8'h08 << i) | i[1:0]);
			chk(engine_power_save, i[0]);
			tick_gap(n);
			chk(n, rgap[i]);
		end
		// Masking hides a pending status bit
		u_mewc_host.wr(8'h31, 8'h05);
		rchk(8'h30, 8'h02);
		chk(irq, 1'b0);
		u_mewc_host.wr(8'h31, 8'h07);
		rchk(8'h31, 8'h07);
		chk(irq, 1'b1);
		u_mewc_host.wr(8'h30, 8'h02);
		// Fields change only while detection is off; every event count
		for (int c = 0; c < 4; c++) begin
			u_mewc_host.wr(8'h27, 8'h00);
			u_mewc_host.wr(8'h27, {3'h0, c[1:0], 3'b001});
			smp(16'd0, 16'd0, 1'b0);
			repeat (c) smp(16'd100, 16'd0, 1'b0);
			smp(16'd100, 16'd0, 1'b1);
		end
		rchk(8'h30, 8'h04);
		chk(irq, 1'b1);
		u_mewc_host.wr(8'h30, 8'h04);
		// A stale hit must not survive a disable
		smp(16'd100, 16'd0, 1'b0);
		u_mewc_host.wr(8'h27, 8'h18);
		smp(16'd100, 16'd0, 1'b0);
		u_mewc_host.wr(8'h27, 8'h19);
		smp(16'd0, 16'd0, 1'b0);
		repeat (3) smp(16'd100, 16'd0, 1'b0);
		smp(16'd100, 16'd0, 1'b1);
		// Previous-sample reference; a wake set meets a status clear in one cycle
		u_mewc_host.wr(8'h30, 8'h04);
		u_mewc_host.wr(8'h27, 8'h00);
		u_mewc_host.wr(8'h27, 8'h02);
		u_mewc_host.wr(8'h27, 8'h03);
		smp(16'd0, 16'd0, 1'b0);
		fork
			smp(16'd100, 16'd0, 1'b1);
			begin
				@(posedge ref_clk);
				u_mewc_host.wr(8'h30, 8'h04);
			end
		join
		rchk(8'h30, 8'h04);
		smp(16'd100, 16'd0, 1'b0);
		smp(16'd0, 16'd0, 1'b1);
		// AND of enabled axes, threshold itself is not over
		u_mewc_host.wr(8'h27, 8'h00);
		u_mewc_host.wr(8'h27, 8'h05);
		smp(16'd0, 16'd0, 1'b0);
		smp(16'd100, 16'd0, 1'b0);
		smp(16'd100, 16'd50, 1'b0);
		smp(16'd100, 16'd100, 1'b1);
		final_report();
	end

endmodule : mewc_top_test
